//--- core/tvd_regs.svh
// constants for the triple video converter input coder
`ifndef TVD_REGS_SVH
`define TVD_REGS_SVH
`define TVD_CODE_W 8
`define TVD_GREEN_W 9
`define TVD_TIP_STEP 9'h070
`define TVD_ZERO_CODE 8'h00
`define TVD_FULL_CODE 8'hFF
`endif

//--- core/tvd_pkg.sv
// types for the triple video converter input coder
`include "tvd_regs.svh"
package tvd_pkg;
    typedef logic [`TVD_CODE_W-1:0] tvd_code_type;
    typedef logic [`TVD_GREEN_W-1:0] tvd_green_type;
endpackage : tvd_pkg

//--- core/tvd_chan.sv
// one gated converter channel code register
`timescale 1ns/100ps
module tvd_chan
    import tvd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire tvd_code_type code,
    input wire logic gate,
    output tvd_code_type code_out
);
    tvd_code_type out_d;
    tvd_code_type out_q;

    // blanking forces code zero
    always_comb begin
        out_d = gate ? code : `TVD_ZERO_CODE;
    end

    // output changes only on a rising edge
    always_ff @(posedge clk) begin
        if (rst) begin
            out_q <= `TVD_ZERO_CODE;
        end else begin
            out_q <= out_d;
        end
    end

    assign code_out = out_q;
endmodule : tvd_chan

//--- core/tvd_coder.sv
// triple video converter input coder top
// Operation
// - there are three channels each taking an unsigned 8-bit code; red and blue are identical, green is 9 bits wide.
// - all three pixel buses are registered on every rising clock edge.
// - channel outputs change only on a rising edge after a fixed latency.
// - with the registered gate low red and blue are driven to code zero, and green to zero plus any tip step.
// - with the gate high each code adds current above the blanking level.
// - with tip control high green gains an extra 112 of 256 steps.
// - with tip control low the extra green step is removed.
// - red and blue are their gated codes and never get the tip step.
// - green is the gated green code plus 112 when tip control is high.
// - codes are straight binary, zero gives zero and all ones full scale.
// - gate and tip control are registered on the same edge as the codes.
`timescale 1ns/100ps
module tvd_coder
    import tvd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire tvd_code_type red_code_in,
    input wire tvd_code_type green_code_in,
    input wire tvd_code_type blue_code_in,
    input wire logic gate_n_in,
    input wire logic tip_n_in,
    output tvd_code_type red_current_out,
    output tvd_green_type green_current_out,
    output tvd_code_type blue_current_out,
    output logic tip_level_source
);
    // input capture stage, same clock as the controller so no synchroniser
    tvd_code_type red_d, red_q, grn_d, grn_q, blu_d, blu_q;
    logic gate_d, gate_q, tip_d, tip_q;
    tvd_green_type green_d, green_q;
    logic tip_src_d, tip_src_q;

    // all inputs captured together so they take effect together
    always_comb begin
        red_d = red_code_in;
        grn_d = green_code_in;
        blu_d = blue_code_in;
        gate_d = gate_n_in;
        tip_d = tip_n_in;
    end

    // capture registers; reset shows blank at sync tip
    always_ff @(posedge clk) begin
        if (rst) begin
            red_q <= `TVD_ZERO_CODE;
            grn_q <= `TVD_ZERO_CODE;
            blu_q <= `TVD_ZERO_CODE;
            gate_q <= 1'b0;
            tip_q <= 1'b0;
        end else begin
            red_q <= red_d;
            grn_q <= grn_d;
            blu_q <= blu_d;
            gate_q <= gate_d;
            tip_q <= tip_d;
        end
    end

    // red and blue are plain gated channels, one instance each
    tvd_chan u_red (
        .clk(clk),
        .rst(rst),
        .code(red_q),
        .gate(gate_q),
        .code_out(red_current_out)
    );
    tvd_chan u_blue (
        .clk(clk),
        .rst(rst),
        .code(blu_q),
        .gate(gate_q),
        .code_out(blue_current_out)
    );

    // green adds the tip step whenever tip control is high, blanked or not;
    // the step adds to pixel data, and the controller holds tip high in active video
    always_comb begin
        green_d = {1'b0, gate_q ? grn_q : `TVD_ZERO_CODE};
        if (tip_q) begin
            green_d = green_d + `TVD_TIP_STEP;
        end
        tip_src_d = tip_q;
    end

    // green output register, one clock behind capture
    always_ff @(posedge clk) begin
        if (rst) begin
            green_q <= 9'h000;
            tip_src_q <= 1'b0;
        end else begin
            green_q <= green_d;
            tip_src_q <= tip_src_d;
        end
    end

    assign green_current_out = green_q;
    assign tip_level_source = tip_src_q;

    // edges since reset left, saturating at two; checks that look two
    // edges back must not reach into reset, where nothing was captured
    logic [1:0] warm_d;
    logic [1:0] warm_q;

    // count up until both pipeline stages hold real samples
    always_comb begin
        warm_d = warm_q;
        if (warm_q != 2'h2) begin
            warm_d = warm_q + 2'h1;
        end
    end

    // warm-up register, cleared by reset
    always_ff @(posedge clk) begin
        if (rst) begin
            warm_q <= 2'h0;
        end else begin
            warm_q <= warm_d;
        end
    end

    // end-to-end checks, two edges from pins to outputs
    a_red_gated: assert property (
        @(posedge clk) disable iff (rst)
        (warm_q == 2'h2) |-> (red_current_out ==
            ($past(gate_n_in, 2) ? $past(red_code_in, 2) : 8'h00)))
        else $error("red code wrong");

    a_blue_gated: assert property (
        @(posedge clk) disable iff (rst)
        (warm_q == 2'h2) |-> (blue_current_out ==
            ($past(gate_n_in, 2) ? $past(blue_code_in, 2) : 8'h00)))
        else $error("blue code wrong");

    a_green_sum: assert property (
        @(posedge clk) disable iff (rst)
        (warm_q == 2'h2) |-> (green_current_out ==
            ({1'b0, ($past(gate_n_in, 2) ?
                $past(green_code_in, 2) : 8'h00)}
            + ($past(tip_n_in, 2) ? 9'h070 : 9'h000))))
        else $error("green code wrong");

    a_tip_flag: assert property (
        @(posedge clk) disable iff (rst)
        (warm_q == 2'h2) |->
            (tip_level_source == $past(tip_n_in, 2)))
        else $error("tip source misaligned");

    a_channels_same: assert property (
        @(posedge clk) disable iff (rst)
        (warm_q == 2'h2 && $past(red_code_in, 2) == $past(blue_code_in, 2))
            |-> (red_current_out == blue_current_out))
        else $error("red and blue channels differ");

    a_green_lo_match: assert property (
        @(posedge clk) disable iff (rst)
        (warm_q == 2'h2 && !$past(tip_n_in, 2) &&
            $past(red_code_in, 2) == $past(green_code_in, 2))
            |-> (green_current_out == {1'b0, red_current_out}))
        else $error("green channel differs from red");

    // blanking and tip step, seen from the pins
    a_tip_blank: assert property (
        @(posedge clk) disable iff (rst)
        (!gate_n_in && tip_n_in) |-> ##2
            (green_current_out == 9'h070))
        else $error("blanked green tip step wrong");

    a_tip_off: assert property (
        @(posedge clk) disable iff (rst)
        (!gate_n_in && !tip_n_in) |-> ##2
            (green_current_out == 9'h000 && red_current_out == 8'h00))
        else $error("sync tip not zero");

    a_red_blank: assert property (
        @(posedge clk) disable iff (rst)
        (!gate_n_in) |-> ##2
            (red_current_out == 8'h00))
        else $error("red not blanked");

    a_blue_blank: assert property (
        @(posedge clk) disable iff (rst)
        (!gate_n_in) |-> ##2
            (blue_current_out == 8'h00))
        else $error("blue not blanked");

    a_green_pass: assert property (
        @(posedge clk) disable iff (rst)
        (gate_n_in && !tip_n_in) |-> ##2
            (green_current_out == {1'b0, $past(green_code_in, 2)}))
        else $error("green active code wrong");

    a_green_lift: assert property (
        @(posedge clk) disable iff (rst)
        (gate_n_in && tip_n_in) |-> ##2 (green_current_out ==
            ({1'b0, $past(green_code_in, 2)} + 9'h070)))
        else $error("green tip step missing");

    a_blue_pass: assert property (
        @(posedge clk) disable iff (rst)
        (gate_n_in) |-> ##2
            (blue_current_out == $past(blue_code_in, 2)))
        else $error("blue active code wrong");

    a_tip_src_low: assert property (
        @(posedge clk) disable iff (rst)
        (!tip_n_in) |-> ##2
            (!tip_level_source))
        else $error("tip source not off");

    a_tip_src_high: assert property (
        @(posedge clk) disable iff (rst)
        (tip_n_in) |-> ##2
            (tip_level_source))
        else $error("tip source not on");

    a_green_msb: assert property (
        @(posedge clk) disable iff (rst)
        (green_current_out[8]) |->
            (tip_level_source))
        else $error("green top bit without tip step");

    // code end points
    a_full_scale: assert property (
        @(posedge clk) disable iff (rst)
        (gate_n_in && red_code_in == 8'hFF) |-> ##2
            (red_current_out == 8'hFF))
        else $error("full scale lost");

    a_blue_full: assert property (
        @(posedge clk) disable iff (rst)
        (gate_n_in && blue_code_in == 8'hFF) |-> ##2
            (blue_current_out == 8'hFF))
        else $error("blue full scale lost");

    a_green_full: assert property (
        @(posedge clk) disable iff (rst)
        (gate_n_in && tip_n_in && green_code_in == 8'hFF) |-> ##2
            (green_current_out == 9'h16F))
        else $error("green full scale lost");

    a_zero_code: assert property (
        @(posedge clk) disable iff (rst)
        (gate_n_in && red_code_in == 8'h00) |-> ##2
            (red_current_out == 8'h00))
        else $error("red zero code wrong");

    a_blue_zero: assert property (
        @(posedge clk) disable iff (rst)
        (gate_n_in && blue_code_in == 8'h00) |-> ##2
            (blue_current_out == 8'h00))
        else $error("blue zero code wrong");

    a_green_max: assert property (
        @(posedge clk) disable iff (rst)
        (green_current_out <= 9'h16F))
        else $error("green out of range");

    // stage by stage checks on the internal registers
    a_capture_red: assert property (
        @(posedge clk) disable iff (rst)
        (warm_q != 2'h0) |-> (red_q == $past(red_code_in)))
        else $error("red capture wrong");

    a_capture_grn: assert property (
        @(posedge clk) disable iff (rst)
        (warm_q != 2'h0) |-> (grn_q == $past(green_code_in)))
        else $error("green capture wrong");

    a_capture_blue: assert property (
        @(posedge clk) disable iff (rst)
        (warm_q != 2'h0) |-> (blu_q == $past(blue_code_in)))
        else $error("blue capture wrong");

    a_capture_gate: assert property (
        @(posedge clk) disable iff (rst)
        (warm_q != 2'h0) |-> (gate_q == $past(gate_n_in)))
        else $error("gate capture wrong");

    a_capture_tip: assert property (
        @(posedge clk) disable iff (rst)
        (warm_q != 2'h0) |-> (tip_q == $past(tip_n_in)))
        else $error("tip capture wrong");

    a_red_out_reg: assert property (
        @(posedge clk) disable iff (rst)
        (warm_q != 2'h0) |-> (red_current_out ==
            ($past(gate_q) ? $past(red_q) : 8'h00)))
        else $error("red output stage wrong");

    a_green_out_reg: assert property (
        @(posedge clk) disable iff (rst)
        (warm_q != 2'h0) |->
            (green_current_out == $past(green_d)))
        else $error("green output stage wrong");

    a_stable_out: assert property (
        @(posedge clk) disable iff (rst)
        ($stable(red_q) && $stable(gate_q)) |=>
            $stable(red_current_out))
        else $error("red changed without cause");

    a_blue_stable: assert property (
        @(posedge clk) disable iff (rst)
        ($stable(blu_q) && $stable(gate_q)) |=>
            $stable(blue_current_out))
        else $error("blue changed without cause");

    a_green_stable: assert property (
        @(posedge clk) disable iff (rst)
        ($stable(grn_q) && $stable(gate_q) && $stable(tip_q)) |=>
            $stable(green_current_out))
        else $error("green changed without cause");

    // reset must leave every output blank at the sync tip
    a_reset_clear: assert property (
        @(posedge clk)
        rst |=> (green_current_out == 9'h000 && red_current_out == 8'h00
            && blue_current_out == 8'h00 && !tip_level_source))
        else $error("outputs not cleared by reset");

    // main scenarios: active video, blanking, sync tip, top code
    c_active: cover property (@(posedge clk) disable iff (rst)
        gate_n_in && tip_n_in);
    c_blank: cover property (@(posedge clk) disable iff (rst)
        !gate_n_in && tip_n_in);
    c_sync_tip: cover property (@(posedge clk) disable iff (rst)
        !gate_n_in && !tip_n_in);
    c_green_top: cover property (@(posedge clk) disable iff (rst)
        green_current_out == 9'h16F);
endmodule : tvd_coder

//--- test/tvd_pix_src.sv
// pixel controller model feeding the coder's pixel bus
`timescale 1ns/100ps
module tvd_pix_src
    import tvd_pkg::*;
(
    input wire logic [31:0] word,
    output tvd_code_type red,
    output tvd_code_type green,
    output tvd_code_type blue,
    output logic gate_n,
    output logic tip_n
);
    // codes taken straight from the word, red in the low byte
    assign red = word[7:0];
    assign green = word[15:8];
    assign blue = word[23:16];
    assign gate_n = word[24];
    // tip held high throughout active video, and taken from word bit 25 while blanked
    assign tip_n = gate_n | word[25];
endmodule : tvd_pix_src

//--- test/tvd_coder_tb.sv
// self-checking bench for the video input coder
`timescale 1ns/100ps
module tvd_coder_tb;
    import tvd_pkg::*;
    logic clk = 0;
    logic rst = 1;
    logic [31:0] word = 32'h03FFFFFF;
    logic [31:0] seed = 32'h0000000C;
    logic [31:0] w;
    logic [31:0] q[$];
    logic [31:0] corner [4] = '{32'h03FFFFFF, 32'h02FFFFFF,
        32'h00FFFFFF, 32'h03000000};
    tvd_code_type r, g, b, ro, bo;
    tvd_green_type go;
    logic gn, tn, to;
    int mismatches = 0;
    int checked = 0;
    tvd_pix_src u_src (.word(word), .red(r), .green(g), .blue(b),
        .gate_n(gn), .tip_n(tn));
    tvd_coder dut (.clk(clk), .rst(rst), .red_code_in(r),
        .green_code_in(g), .blue_code_in(b), .gate_n_in(gn),
        .tip_n_in(tn), .red_current_out(ro), .green_current_out(go),
        .blue_current_out(bo), .tip_level_source(to));
    // random words; corners come first so 00 and FF codes are seen
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string name, input logic [8:0] seen,
        input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    initial begin
        forever #2 clk = ~clk;
    end
    // watchdog well beyond the 208 cycles the sequence takes
    initial begin
        #2000;
        mismatches++;
        complete_run();
    end
    // model: outputs show the word applied two edges earlier
    initial begin
        repeat (8) @(posedge clk);
        #1;
        check("reset green", go, 9'h000);
        check("reset red", {1'b0, ro}, 9'h000);
        rst = 0;
        for (int k = 0; k < 200; k++) begin
            if (q.size() == 2) begin
                w = q.pop_front();
                check("red", {1'b0, ro},
                    w[24] ? {1'b0, w[7:0]} : 9'h000);
                check("blue", {1'b0, bo},
                    w[24] ? {1'b0, w[23:16]} : 9'h000);
                check("green", go, (w[24] ? {1'b0, w[15:8]} : 9'h000)
                    + ((w[24] | w[25]) ? 9'h070 : 9'h000));
                check("tip", {8'h00, to},
                    {8'h00, w[24] | w[25]});
            end
            seed = lfsr(seed);
            word = (k < 4) ? corner[k] : seed;
            q.push_back(word);
            @(posedge clk);
            #1;
        end
        complete_run();
    end
endmodule : tvd_coder_tb
